/* src/ccsp_pkg.sv */
package ccsp_pkg;

  // Frame shape: one command byte, then one data byte
  localparam int BYTE_W = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam int CMD_READ_BIT = 6; // Position in the byte held before the last bit enters

  // Register selects carried in the low seven bits of the command byte
  localparam logic [6:0] SEL_CR_ZERO = 7'h00;
  localparam logic [6:0] SEL_CR_ONE = 7'h01;
  localparam logic [6:0] SEL_STATUS = 7'h02;

  // Field layout
  localparam int CR0_ALT_LSB = 4;
  localparam int CR1_FLAG_BIT = 0;
  localparam int STAT_KEY_BIT = 0;
  localparam int STAT_FLAG_BIT = 1;

  // Reset values
  localparam logic [7:0] CR0_RST = 8'h00;
  localparam logic [7:0] CR1_RST = 8'h00;

  // Reference clock choices and divide ratios down to the 512 kHz internal rate
  localparam logic [1:0] ALT_512K = 2'h0;
  localparam logic [1:0] ALT_1536K = 2'h1;
  localparam logic [1:0] ALT_2048K = 2'h2;
  localparam logic [1:0] ALT_2560K = 2'h3;
  localparam logic [2:0] DIV_512K = 3'h1;
  localparam logic [2:0] DIV_1536K = 3'h3;
  localparam logic [2:0] DIV_2048K = 3'h4;
  localparam logic [2:0] DIV_2560K = 3'h5;

  // Synchroniser reset levels match the idle select, shift clock and key pins (data resets low), so no false shift clock edge follows reset
  // Bit order {cs_n, sclk, di, key}
  localparam logic [3:0] SYNC_RST = 4'h9;

  typedef enum logic [1:0] {ST_CMD, ST_DATA, ST_DONE} ccsp_state_t;

  // Divider ratio for a given reference clock selection
  function automatic logic [2:0] ccsp_div_ratio(input logic [1:0] sel);
    logic [2:0] r;
    r = DIV_512K;
    unique case (sel)
      ALT_512K: r = DIV_512K;
      ALT_1536K: r = DIV_1536K;
      ALT_2048K: r = DIV_2048K;
      ALT_2560K: r = DIV_2560K;
    endcase
    return r;
  endfunction

endpackage

/* src/ccsp_sync3.sv */
`timescale 1ns/10ps
// Three-stage pin synchroniser; the level only moves once stages two and three agree
module ccsp_sync3 #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Pins and clean levels
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // Stage one feeds stage two only, avoiding any look at a metastable value
      always_ff @(posedge core_clk)
      begin
        if (sys_rst)
        begin
          s1_reg[i] <= RST_VAL[i];
          s2_reg[i] <= RST_VAL[i];
          s3_reg[i] <= RST_VAL[i];
          level_out[i] <= RST_VAL[i];
        end
        else
        begin
          s1_reg[i] <= pin_in[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          if (s2_reg[i] == s3_reg[i])
            level_out[i] <= s3_reg[i];
        end
      end
    end
  endgenerate

endmodule // ccsp_sync3

/* src/ccsp_top.sv */
`timescale 1ns/10ps
// Notes on behaviour
// R01: Sample input bit on each shift clock rise
// R02: Transfers happen only while chip-select is low
// R03: Shift clock moves bits in or out
// R04: Unrelated shift clock synchronised before register updates
// R05: Inverted flag pin shows complement of flag
// R06: Keypad input low means key pressed
// R07: Reference clock field sets the divider ratio
// R08: Reference clock never shifts sample data
// R09: Status bits change on shift clock fall
// R10: Reset returns inverted flag pin high
// R11: Chip-select release abandons transfer, output inactive
module ccsp_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Serial control pins
  input wire logic ctrl_shift_clock,
  input wire logic chip_select_n,
  input wire logic instr_shift_in,
  output logic status_shift_out,
  output logic status_shift_out_oe,
  // Side pins
  input wire logic keypad_sense_in,
  output logic keypad_event_out,
  output logic keypad_pressed,
  output logic inverted_flag_pin,
  // Reference clock divider setting
  output logic [1:0] alt_ref_sel,
  output logic [2:0] alt_div_ratio
);

  typedef struct packed {
    logic sclk_prev;
    ccsp_pkg::ccsp_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic is_read;
    logic [6:0] sel;
    logic [7:0] out_sh;
    logic so;
    logic oe;
    logic [7:0] ctrl_reg_zero;
    logic [7:0] ctrl_reg_one;
    logic inv_flag;
    logic key_pressed;
    logic key_event;
    logic [2:0] div_ratio;
  } ccsp_ctl_t;

  localparam ccsp_ctl_t CTL_RST = '{
    sclk_prev: 1'b0,
    state: ccsp_pkg::ST_CMD,
    bit_cnt: ccsp_pkg::BIT_FIRST,
    shreg: 8'h00,
    is_read: 1'b0,
    sel: ccsp_pkg::SEL_CR_ZERO,
    out_sh: 8'h00,
    so: 1'b0,
    oe: 1'b0,
    ctrl_reg_zero: ccsp_pkg::CR0_RST,
    ctrl_reg_one: ccsp_pkg::CR1_RST,
    inv_flag: 1'b1,
    key_pressed: 1'b0,
    key_event: 1'b0,
    div_ratio: ccsp_pkg::DIV_512K
  };

  ccsp_ctl_t ctl_reg;
  ccsp_ctl_t ctl_next;
  logic [3:0] pin_lvl;
  logic cs_n_lvl;
  logic sclk_lvl;
  logic di_lvl;
  logic key_lvl;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] byte_in;

  // Readback mux for a register select
  function automatic logic [7:0] read_sel(input logic [6:0] s, input ccsp_ctl_t c);
    logic [7:0] d;
    d = 8'h00;
    if (s == ccsp_pkg::SEL_CR_ZERO)
      d = c.ctrl_reg_zero;
    else if (s == ccsp_pkg::SEL_CR_ONE)
      d = c.ctrl_reg_one;
    else if (s == ccsp_pkg::SEL_STATUS)
    begin
      d[ccsp_pkg::STAT_KEY_BIT] = c.key_pressed;
      d[ccsp_pkg::STAT_FLAG_BIT] = c.ctrl_reg_one[ccsp_pkg::CR1_FLAG_BIT];
    end
    return d;
  endfunction

  // All pins are asynchronous to core_clk, shift clock included
  ccsp_sync3 #(
    .WIDTH(4),
    .RST_VAL(ccsp_pkg::SYNC_RST)
  ) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in({chip_select_n, ctrl_shift_clock, instr_shift_in, keypad_sense_in}),
    .level_out(pin_lvl)
  );

  // Clean levels and shift clock edges, seen in the core domain
  assign cs_n_lvl = pin_lvl[3];
  assign sclk_lvl = pin_lvl[2];
  assign di_lvl = pin_lvl[1];
  assign key_lvl = pin_lvl[0];
  assign sclk_rise = sclk_lvl && !ctl_reg.sclk_prev; // R04
  assign sclk_fall = !sclk_lvl && ctl_reg.sclk_prev;
  assign byte_in = {ctl_reg.shreg[6:0], di_lvl};

  // Next-state logic for the whole port
  always_comb
  begin
    ctl_next = ctl_reg;
    ctl_next.sclk_prev = sclk_lvl;
    ctl_next.key_pressed = !key_lvl; // R06
    ctl_next.key_event = !key_lvl && !ctl_reg.key_pressed;
    if (cs_n_lvl)
    begin
      // Partial frames are dropped so the next one starts from bit zero
      ctl_next.state = ccsp_pkg::ST_CMD; // R11
      ctl_next.bit_cnt = ccsp_pkg::BIT_FIRST;
      ctl_next.oe = 1'b0; // R02
      ctl_next.so = 1'b0;
    end
    else
    begin
      ctl_next.oe = 1'b1;
      if (sclk_rise)
      begin
        ctl_next.shreg = byte_in; // R01
        ctl_next.bit_cnt = ctl_reg.bit_cnt + 3'h1;
        unique case (ctl_reg.state)
          ccsp_pkg::ST_CMD:
          begin
            if (ctl_reg.bit_cnt == ccsp_pkg::BIT_LAST)
            begin
              // Command decides the direction of the data byte
              ctl_next.is_read = ctl_reg.shreg[ccsp_pkg::CMD_READ_BIT]; // R03
              ctl_next.sel = byte_in[6:0];
              ctl_next.out_sh = read_sel(byte_in[6:0], ctl_reg);
              ctl_next.state = ccsp_pkg::ST_DATA;
            end
          end
          ccsp_pkg::ST_DATA:
          begin
            if (ctl_reg.bit_cnt == ccsp_pkg::BIT_LAST)
            begin
              ctl_next.state = ccsp_pkg::ST_DONE;
              // Writes land in one core cycle, never on the raw shift clock
              if (!ctl_reg.is_read && ctl_reg.sel == ccsp_pkg::SEL_CR_ZERO)
                ctl_next.ctrl_reg_zero = byte_in; // R04
              if (!ctl_reg.is_read && ctl_reg.sel == ccsp_pkg::SEL_CR_ONE)
                ctl_next.ctrl_reg_one = byte_in; // R04
            end
          end
          ccsp_pkg::ST_DONE:
          begin
            ctl_next.bit_cnt = ctl_reg.bit_cnt; // Extra bits ignored until release
          end
        endcase
      end
      if (sclk_fall && ctl_reg.state == ccsp_pkg::ST_DATA && ctl_reg.is_read)
      begin
        ctl_next.so = ctl_reg.out_sh[7]; // R09
        ctl_next.out_sh = {ctl_reg.out_sh[6:0], 1'b0};
      end
    end
    ctl_next.inv_flag = !ctl_next.ctrl_reg_one[ccsp_pkg::CR1_FLAG_BIT]; // R05
    // Ratio feeds the filter clock divider only; sample shifting stays on the master clock
    ctl_next.div_ratio = ccsp_pkg::ccsp_div_ratio(
      ctl_next.ctrl_reg_zero[ccsp_pkg::CR0_ALT_LSB +: 2]); // R07 R08
  end

  // Reset also clears the flag, so the pin goes high and the host sees it
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      ctl_reg <= CTL_RST; // R10
    else
      ctl_reg <= ctl_next;
  end

  // Outputs straight from the state register
  assign status_shift_out = ctl_reg.so;
  assign status_shift_out_oe = ctl_reg.oe;
  assign keypad_event_out = ctl_reg.key_event;
  assign keypad_pressed = ctl_reg.key_pressed;
  assign inverted_flag_pin = ctl_reg.inv_flag;
  assign alt_ref_sel = ctl_reg.ctrl_reg_zero[ccsp_pkg::CR0_ALT_LSB +: 2];
  assign alt_div_ratio = ctl_reg.div_ratio;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // Checks on the port behaviour
  a_rise_samples_di: assert property ( // R01
    (!cs_n_lvl && sclk_rise) |=> (ctl_reg.shreg[0] == $past(di_lvl)))
    else $error("input bit not sampled on shift clock rise");
  a_idle_out_off: assert property ( // R02
    cs_n_lvl |=> (!status_shift_out_oe && !status_shift_out))
    else $error("serial output active while deselected");
  a_select_drives_oe: assert property ( // R02
    (!cs_n_lvl) |=> status_shift_out_oe)
    else $error("serial output not enabled while selected");
  a_cmd_sets_dir: assert property ( // R03
    (!cs_n_lvl && sclk_rise && ctl_reg.state == ccsp_pkg::ST_CMD
      && ctl_reg.bit_cnt == ccsp_pkg::BIT_LAST)
    |=> (ctl_reg.state == ccsp_pkg::ST_DATA && ctl_reg.is_read == $past(ctl_reg.shreg[6])))
    else $error("command byte did not set direction");
  a_write_lands_once: assert property ( // R04
    (!cs_n_lvl && sclk_rise && ctl_reg.state == ccsp_pkg::ST_DATA && !ctl_reg.is_read
      && ctl_reg.sel == ccsp_pkg::SEL_CR_ONE && ctl_reg.bit_cnt == ccsp_pkg::BIT_LAST)
    |=> (ctl_reg.ctrl_reg_one == $past(byte_in)) ##1 $stable(ctl_reg.ctrl_reg_one))
    else $error("control register write lost");
  a_flag_pin_inv: assert property ( // R05
    ##1 (inverted_flag_pin != ctl_reg.ctrl_reg_one[ccsp_pkg::CR1_FLAG_BIT]))
    else $error("inverted flag pin not complement of flag");
  a_key_polarity: assert property ( // R06
    ##1 (keypad_pressed == !$past(key_lvl)))
    else $error("keypad level polarity wrong");
  a_ratio_follows: assert property ( // R07
    $changed(alt_ref_sel) |-> (alt_div_ratio == ccsp_pkg::ccsp_div_ratio(alt_ref_sel)))
    else $error("divider ratio does not match selection");
  a_out_on_fall: assert property ( // R09
    $changed(status_shift_out) |-> ($past(sclk_fall) || $past(cs_n_lvl)))
    else $error("status output moved off a falling edge");
  a_reset_pin_high: assert property ( // R10
    @(posedge core_clk) disable iff (1'b0) $past(sys_rst) |-> inverted_flag_pin)
    else $error("flag pin not high after reset");
  a_release_clean: assert property ( // R11
    $rose(cs_n_lvl) |=> (ctl_reg.state == ccsp_pkg::ST_CMD
      && ctl_reg.bit_cnt == ccsp_pkg::BIT_FIRST) [*2])
    else $error("transfer not abandoned on deselect");

  c_read_frame: cover property (
    ctl_reg.state == ccsp_pkg::ST_DATA && ctl_reg.is_read && sclk_fall);
  c_write_cr1: cover property ($changed(ctl_reg.ctrl_reg_one));
  c_key_press: cover property (keypad_event_out);
  c_abort_mid: cover property (ctl_reg.state == ccsp_pkg::ST_DATA ##1 cs_n_lvl);

endmodule // ccsp_top

/* testbench/ccsp_host.sv */
`timescale 1ns/10ps
// Host side of the control link: drives select, shift clock and data
module ccsp_host #(
  parameter int HALF = 8
) (
  // Clock
  input wire logic core_clk,
  // Link pins
  input wire logic status_shift_out,
  output logic ctrl_shift_clock,
  output logic chip_select_n,
  output logic instr_shift_in
);
  // Idle: clock parked low between frames, select high
  initial
  begin
    ctrl_shift_clock = 1'b0;
    chip_select_n = 1'b1;
    instr_shift_in = 1'b1;
  end
  // Whole core cycles, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // n bits MSB first; sel_n high clocks the link without selecting
  task automatic frame(input logic [15:0] tx, input int n, input logic sel_n,
      output logic [7:0] rx);
    rx = 8'h00;
    tick(1);
    chip_select_n = sel_n;
    tick(HALF);
    for (int i = 0; i < n; i++)
    begin
      instr_shift_in = tx[15-i];
      tick(HALF);
      ctrl_shift_clock = 1'b1;
      if (i >= 8)
        rx[15-i] = status_shift_out;
      tick(HALF);
      ctrl_shift_clock = 1'b0;
    end
    tick(HALF);
    chip_select_n = 1'b1;
    // Released line flips so a stale bit cannot pass for data
    instr_shift_in = ~instr_shift_in;
    tick(HALF);
  endtask
endmodule // ccsp_host

/* testbench/ccsp_top_tb.sv */
`timescale 1ns/10ps
module ccsp_top_tb;
  logic core_clk, sys_rst, sclk, cs_n, di, sdo, sdo_oe, key_in, key_ev, key_prs, flag_n;
  logic [1:0] sel;
  logic [2:0] div;
  logic [7:0] rx;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h77DD;
  int bad_count = 0, checks = 0, cycles = 0, ev_cnt = 0;
  int cr0 = 0, cr1 = 0, key = 0;
  int div_tab[4] = '{1, 3, 4, 5};

  ccsp_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .ctrl_shift_clock(sclk),
    .chip_select_n(cs_n), .instr_shift_in(di), .status_shift_out(sdo),
    .status_shift_out_oe(sdo_oe), .keypad_sense_in(key_in), .keypad_event_out(key_ev),
    .keypad_pressed(key_prs), .inverted_flag_pin(flag_n), .alt_ref_sel(sel),
    .alt_div_ratio(div));
  ccsp_host host (.core_clk(core_clk), .status_shift_out(sdo), .ctrl_shift_clock(sclk),
    .chip_select_n(cs_n), .instr_shift_in(di));

  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Cycle ceiling well above the roughly 5000 cycles the run needs
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      bad_count++;
      finish_test();
    end
  end

  // Press pulses counted mid-cycle, where the registered output has settled
  always @(negedge core_clk)
  begin
    if (key_ev === 1'b1)
      ev_cnt++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bench model of what a read returns
  function automatic logic [7:0] model_rd(input int s);
    if (s == 0)
      return cr0[7:0];
    if (s == 1)
      return cr1[7:0];
    if (s == 2)
      return {6'h00, cr1[0], key[0]};
    return 8'h00;
  endfunction

  task automatic wr(input int s, input int d);
    host.frame({1'b0, s[6:0], d[7:0]}, 16, 1'b0, rx);
    if (s == 0)
      cr0 = d;
    else if (s == 1)
      cr1 = d;
  endtask

  task automatic rd(input int s);
    exp_q.push_back(model_rd(s));
    host.frame({1'b1, s[6:0], 8'h00}, 16, 1'b0, rx);
    check("readback", rx, exp_q.pop_front());
  endtask

  task automatic outs();
    check("flag pin", {7'h00, flag_n}, cr1[0] ? 8'h00 : 8'h01);
    check("ref select", {6'h00, sel}, 8'((cr0 >> 4) & 3));
    check("divider", {5'h00, div}, 8'(div_tab[(cr0 >> 4) & 3]));
    check("oe idle", {7'h00, sdo_oe}, 8'h00);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    sys_rst = 1'b1;
    key_in = 1'b1;
    repeat (6) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
    outs();
    // Every reference clock choice, random neighbouring bits
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      wr(0, int'(seed[7:0] & 8'hCF) | (k << 4));
      rd(0);
      outs();
    end
    $display("test clock select done");
    // Flag set and cleared, status readback
    wr(1, 1);
    outs();
    rd(2);
    rd(1);
    wr(1, 0);
    outs();
    wr(1, 1);
    $display("test flag done");
    // Key press then release
    key_in = 1'b0;
    key = 1;
    repeat (10) @(posedge core_clk);
    #1 check("pressed", {7'h00, key_prs}, 8'h01);
    rd(2);
    key_in = 1'b1;
    key = 0;
    repeat (10) @(posedge core_clk);
    #1 check("released", {7'h00, key_prs}, 8'h00);
    check("press events", 8'(ev_cnt), 8'h01);
    $display("test keypad done");
    // Aborted frame, unselected clocks, unmapped select
    host.frame(16'h0100, 12, 1'b0, rx);
    outs();
    host.frame(16'h0100, 16, 1'b1, rx);
    outs();
    wr(5, 8'h5A);
    rd(5);
    outs();
    $display("test refusals done");
    // Reset in mid-run with the flag pin low
    @(posedge core_clk);
    #1 sys_rst = 1'b1;
    cr0 = 0;
    cr1 = 0;
    repeat (6) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    outs();
    $display("test reset done");
    finish_test();
  end
endmodule // ccsp_top_tb
